// ---- design/sei_map.vh ----
// register offsets, field positions, reset values for the sensor event logic
`ifndef SEI_MAP_VH
`define SEI_MAP_VH

// ==========================================================
// register byte addresses (word aligned)
`define SEI_A_PIN_CFG      8'h0C
`define SEI_A_EVT_ENABLE   8'h10
`define SEI_A_MODE_A       8'h14
`define SEI_A_MODE_B       8'h18
`define SEI_A_STATUS       8'h84
`define SEI_A_PROX_TH1     8'h44
`define SEI_A_PROX_TH2     8'h4C
`define SEI_A_PROX_TH3     8'h54
`define SEI_A_AMB_LOW_TH   8'h2C
`define SEI_A_AMB_HIGH_TH  8'h34
`define SEI_A_PROX_HYST    8'h58
`define SEI_A_PROX_HIST    8'h5C

// ==========================================================
// field positions
`define SEI_PIN_OE         0
`define SEI_PIN_DEASSERT   1
`define SEI_EN_PROX1       2
`define SEI_EN_PROX2       3
`define SEI_EN_PROX3       4
`define SEI_EN_CMD         5
`define SEI_MA_PROX1_LSB   4
`define SEI_MA_PROX2_LSB   6
`define SEI_MB_PROX3_LSB   0
`define SEI_MB_CMD_LSB     2

// ==========================================================
// reset values and encodings
`define SEI_RST_BYTE       8'h00
`define SEI_RST_THRESH     16'h0000
`define SEI_PM_EVERY       2'h0
`define SEI_PM_CROSS       2'h1
`define SEI_PM_ABOVE       2'h3
`define SEI_STATUS_W       6

`endif

// ---- design/sei_prox_chan.v ----
// one proximity channel event detector with hysteresis and history filter
`timescale 1ns/10ps
module sei_prox_chan (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        clk_en,
   input  wire        enable,
   input  wire [1:0]  mode,
   input  wire [7:0]  threshold,
   input  wire [7:0]  hysteresis,
   input  wire [7:0]  history,
   input  wire        sample_vld,
   input  wire [15:0] sample,
   output wire        event_hit
);

`include "sei_map.vh"

   // ==========================================================
   // compressed 8-bit value: upper nibble exponent, lower mantissa
   function [15:0] sei_expand;
      input [7:0] c;
      reg   [19:0] t;
      begin
         t = {15'h0000, 1'b1, c[3:0]} << c[7:4];
         sei_expand = (t[19:4] == 16'h0000) ? 16'h0000 : t[19:4];
      end
   endfunction

   // ==========================================================
   wire [15:0] th_lin   = sei_expand(threshold);
   wire [15:0] hy_lin   = sei_expand(hysteresis);
   wire [16:0] up_lim   = {1'b0, th_lin} + {1'b0, hy_lin};
   wire [15:0] dn_lim   = (th_lin > hy_lin) ? th_lin - hy_lin : 16'h0000;

   reg         state_ff;   // last qualified side: 1 = above
   reg  [7:0]  hist_ff;    // shift of raw above results
   reg         nxt_state;
   reg  [7:0]  nxt_hist;
   reg         raw_above;
   reg         qual_above;
   reg         hit;

   always @* begin
      raw_above = state_ff ? ({1'b0, sample} > {1'b0, dn_lim})
                           : ({1'b0, sample} > up_lim);
      nxt_hist  = {hist_ff[6:0], raw_above};
      // history: every sample in the checked window must agree;
      // an empty mask lets the state follow each raw result at once
      if (history == 8'h00)
         qual_above = raw_above;
      else if ((nxt_hist & history) == history)
         qual_above = 1'b1;
      else if ((nxt_hist & history) == 8'h00)
         qual_above = 1'b0;
      else
         qual_above = state_ff;
      nxt_state = qual_above;
      hit = 1'b0;
      if (enable && sample_vld) begin
         case (mode)
            `SEI_PM_EVERY: hit = 1'b1;
            `SEI_PM_CROSS: hit = (qual_above != state_ff);
            `SEI_PM_ABOVE: hit = qual_above;
            default:       hit = 1'b0;
         endcase
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= 1'b0;
         hist_ff  <= 8'h00;
      end else if (clk_en && sample_vld) begin
         state_ff <= nxt_state;
         hist_ff  <= nxt_hist;
      end
   end

   assign event_hit = hit;

endmodule

// ---- design/sei_event_logic.v ----
// sensor event status, enable and interrupt pin logic on an ahb-lite slave
// Notes on behaviour
// - enable and both mode registers decide when status bits set
// - prox channel 1 enable bit 2; mode 00 sets flag every sample
// - prox channel 1 mode 01 sets flag on threshold crossing
// - prox channel 1 mode 11 sets flag while sample above threshold
// - threshold events pass shared hysteresis and history check
// - prox thresholds read in compressed format, not linear counts
// - prox channel 2 uses enable bit 3 and mode a bits 7:6
// - prox channel 3 uses enable bit 4 and mode b bits 1:0
// - ambient enable 1:0, mode 2:0; enable 01 mode 000 every visible
// - enable 0, mode 1:0 = 01: visible leaving window sets flag 0
// - enable 1, mode 2:1 = 10: visible entering window sets flag 1
// - enable 0, mode 1:0 = 11: infrared leaving window sets flag 0
// - enable 1, mode 2:1 = 11: infrared entering window sets flag 1
// - pin asserts when output enable set and enable AND status nonzero
// - writing one clears a status bit unless pin cfg bit 1 is set; zero leaves it alone
// - command event: mode 0 every response, mode 1 every response with error set
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module sei_event_logic (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        clk_en,
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        prox1_vld,
   input  wire [15:0] prox1_sample,
   input  wire        prox2_vld,
   input  wire [15:0] prox2_sample,
   input  wire        prox3_vld,
   input  wire [15:0] prox3_sample,
   input  wire        visible_vld,
   input  wire [15:0] visible_light_channel,
   input  wire        infrared_vld,
   input  wire [15:0] infrared_light_channel,
   input  wire        cmd_response_vld,
   input  wire        cmd_response_err,
   output reg         irq_out
);

`include "sei_map.vh"

   // ==========================================================
   // registers
   reg [7:0]  pin_cfg_ff;
   reg [7:0]  event_enable_ff;
   reg [7:0]  event_mode_reg_a_ff;
   reg [7:0]  event_mode_reg_b_ff;
   reg [`SEI_STATUS_W-1:0] status_ff;
   reg [7:0]  th_ff [0:2];
   reg [15:0] ambient_low_threshold_ff;
   reg [15:0] ambient_high_threshold_ff;
   reg [7:0]  prox_hysteresis_ff;
   reg [7:0]  prox_history_check_ff;
   reg        amb_in_vis_ff;
   reg        amb_in_ir_ff;

   // ==========================================================
   // ahb-lite address phase capture, zero wait state
   reg        wr_pend_ff;
   reg [7:0]  wr_addr_ff;
   wire       take = hsel && hready && htrans[1];

   function is_mapped;
      input [7:0] a;
      begin
         case (a)
            `SEI_A_PIN_CFG, `SEI_A_EVT_ENABLE, `SEI_A_MODE_A,
            `SEI_A_MODE_B, `SEI_A_STATUS, `SEI_A_PROX_TH1,
            `SEI_A_PROX_TH2, `SEI_A_PROX_TH3, `SEI_A_AMB_LOW_TH,
            `SEI_A_AMB_HIGH_TH, `SEI_A_PROX_HYST,
            `SEI_A_PROX_HIST: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
         endcase
      end
   endfunction

   reg [31:0] rd_val;
   always @* begin
      case (haddr)
         `SEI_A_PIN_CFG:     rd_val = {24'h000000, pin_cfg_ff};
         `SEI_A_EVT_ENABLE:  rd_val = {24'h000000, event_enable_ff};
         `SEI_A_MODE_A:      rd_val = {24'h000000, event_mode_reg_a_ff};
         `SEI_A_MODE_B:      rd_val = {24'h000000, event_mode_reg_b_ff};
         `SEI_A_STATUS:      rd_val = {26'h0000000, status_ff};
         `SEI_A_PROX_TH1:    rd_val = {24'h000000, th_ff[0]};
         `SEI_A_PROX_TH2:    rd_val = {24'h000000, th_ff[1]};
         `SEI_A_PROX_TH3:    rd_val = {24'h000000, th_ff[2]};
         `SEI_A_AMB_LOW_TH:  rd_val = {16'h0000, ambient_low_threshold_ff};
         `SEI_A_AMB_HIGH_TH: rd_val = {16'h0000, ambient_high_threshold_ff};
         `SEI_A_PROX_HYST:   rd_val = {24'h000000, prox_hysteresis_ff};
         `SEI_A_PROX_HIST:   rd_val = {24'h000000, prox_history_check_ff};
         default:            rd_val = 32'h00000000;
      endcase
   end

   wire wr_now = wr_pend_ff && clk_en;
   wire [7:0] wb = hwdata[7:0];

   // ==========================================================
   // proximity channels
   wire [2:0] prox_hit;
   wire [2:0] prox_vld = {prox3_vld, prox2_vld, prox1_vld};
   wire [47:0] prox_smp = {prox3_sample, prox2_sample, prox1_sample};
   wire [5:0] prox_mode = {
      event_mode_reg_b_ff[`SEI_MB_PROX3_LSB+1:`SEI_MB_PROX3_LSB],
      event_mode_reg_a_ff[`SEI_MA_PROX2_LSB+1:`SEI_MA_PROX2_LSB],
      event_mode_reg_a_ff[`SEI_MA_PROX1_LSB+1:`SEI_MA_PROX1_LSB]};
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_prox
         sei_prox_chan u_chan (
            .hclk       (hclk),
            .hresetn    (hresetn),
            .clk_en     (clk_en),
            .enable     (event_enable_ff[`SEI_EN_PROX1+g]),
            .mode       (prox_mode[2*g+1:2*g]),
            .threshold  (th_ff[g]),
            .hysteresis (prox_hysteresis_ff),
            .history    (prox_history_check_ff),
            .sample_vld (prox_vld[g]),
            .sample     (prox_smp[16*g+15:16*g]),
            .event_hit  (prox_hit[g])
         );
      end
   endgenerate

   // ==========================================================
   // ambient window events
   wire [1:0] amb_en = event_enable_ff[1:0];
   wire [2:0] amb_md = event_mode_reg_a_ff[2:0];
   wire vis_in = (visible_light_channel >= ambient_low_threshold_ff) &&
                 (visible_light_channel <= ambient_high_threshold_ff);
   wire ir_in  = (infrared_light_channel >= ambient_low_threshold_ff) &&
                 (infrared_light_channel <= ambient_high_threshold_ff);
   reg [1:0] amb_hit;
   always @* begin
      amb_hit = 2'b00;
      if (amb_en == 2'b01 && amb_md == 3'b000 && visible_vld)
         amb_hit[0] = 1'b1;
      if (amb_en[0] && amb_md[1:0] == 2'b01 && visible_vld &&
          amb_in_vis_ff && !vis_in)
         amb_hit[0] = 1'b1;
      if (amb_en[0] && amb_md[1:0] == 2'b11 && infrared_vld &&
          amb_in_ir_ff && !ir_in)
         amb_hit[0] = 1'b1;
      if (amb_en[1] && amb_md[2:1] == 2'b10 && visible_vld &&
          !amb_in_vis_ff && vis_in)
         amb_hit[1] = 1'b1;
      if (amb_en[1] && amb_md[2:1] == 2'b11 && infrared_vld &&
          !amb_in_ir_ff && ir_in)
         amb_hit[1] = 1'b1;
   end

   // ==========================================================
   // command event
   wire [1:0] cmd_md = event_mode_reg_b_ff[`SEI_MB_CMD_LSB+1:`SEI_MB_CMD_LSB];
   wire cmd_hit = event_enable_ff[`SEI_EN_CMD] && cmd_response_vld &&
                  (!cmd_md[0] || cmd_response_err);

   wire [`SEI_STATUS_W-1:0] set_vec = {cmd_hit, prox_hit, amb_hit};
   reg  [`SEI_STATUS_W-1:0] clr_vec;
   always @* begin
      clr_vec = {`SEI_STATUS_W{1'b0}};
      // policy bit one leaves clearing to a later design; writes ignored
      if (wr_now && wr_addr_ff == `SEI_A_STATUS &&
          !pin_cfg_ff[`SEI_PIN_DEASSERT])
         clr_vec = wb[`SEI_STATUS_W-1:0];
   end
   // set wins over a clear in the same cycle
   wire [`SEI_STATUS_W-1:0] nxt_status = (status_ff & ~clr_vec) | set_vec;

   wire nxt_irq = pin_cfg_ff[`SEI_PIN_OE] &&
                  |(event_enable_ff[`SEI_STATUS_W-1:0] & nxt_status);

   // ==========================================================
   // sequential
   integer i;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_cfg_ff                <= `SEI_RST_BYTE;
         event_enable_ff           <= `SEI_RST_BYTE;
         event_mode_reg_a_ff       <= `SEI_RST_BYTE;
         event_mode_reg_b_ff       <= `SEI_RST_BYTE;
         status_ff                 <= {`SEI_STATUS_W{1'b0}};
         for (i = 0; i < 3; i = i + 1)
            th_ff[i] <= `SEI_RST_BYTE;
         ambient_low_threshold_ff  <= `SEI_RST_THRESH;
         ambient_high_threshold_ff <= `SEI_RST_THRESH;
         prox_hysteresis_ff        <= `SEI_RST_BYTE;
         prox_history_check_ff     <= `SEI_RST_BYTE;
         amb_in_vis_ff             <= 1'b0;
         amb_in_ir_ff              <= 1'b0;
         wr_pend_ff                <= 1'b0;
         wr_addr_ff                <= 8'h00;
         hrdata                    <= 32'h00000000;
         hreadyout                 <= 1'b1;
         hresp                     <= 1'b0;
         irq_out                   <= 1'b0;
      end else if (clk_en) begin
         wr_pend_ff <= take && hwrite && is_mapped(haddr);
         wr_addr_ff <= haddr;
         if (take && !hwrite)
            hrdata <= rd_val;
         status_ff <= nxt_status;
         irq_out   <= nxt_irq;
         if (visible_vld)
            amb_in_vis_ff <= vis_in;
         if (infrared_vld)
            amb_in_ir_ff <= ir_in;
         if (wr_now) begin
            case (wr_addr_ff)
               `SEI_A_PIN_CFG:     pin_cfg_ff <= wb;
               `SEI_A_EVT_ENABLE:  event_enable_ff <= wb;
               `SEI_A_MODE_A:      event_mode_reg_a_ff <= wb;
               `SEI_A_MODE_B:      event_mode_reg_b_ff <= wb;
               `SEI_A_PROX_TH1:    th_ff[0] <= wb;
               `SEI_A_PROX_TH2:    th_ff[1] <= wb;
               `SEI_A_PROX_TH3:    th_ff[2] <= wb;
               `SEI_A_AMB_LOW_TH:  ambient_low_threshold_ff <= hwdata[15:0];
               `SEI_A_AMB_HIGH_TH: ambient_high_threshold_ff <= hwdata[15:0];
               `SEI_A_PROX_HYST:   prox_hysteresis_ff <= wb;
               `SEI_A_PROX_HIST:   prox_history_check_ff <= wb;
               default: ;
            endcase
         end
      end
   end

endmodule

// ---- test/sei_chk.sv ----
// checker: bus answer and interrupt pin timing of the event logic
`timescale 1ns/10ps
`include "sei_map.vh"
module sei_chk (
   input wire        hclk,
   input wire        hresetn,
   input wire        clk_en,
   input wire        hsel,
   input wire [7:0]  haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire [31:0] hwdata,
   input wire        hreadyout,
   input wire        hresp,
   input wire        prox1_vld,
   input wire        prox2_vld,
   input wire        prox3_vld,
   input wire        visible_vld,
   input wire        infrared_vld,
   input wire        cmd_response_vld,
   input wire        irq_out
);
   logic       wr_ff;
   logic [7:0] a_ff;
   logic [7:0] cfg_ff;
   logic [7:0] en_ff;
   logic [7:0] ma_ff;
   logic [7:0] mb_ff;
   wire        ev = prox1_vld | prox2_vld | prox3_vld | visible_vld |
                    infrared_vld | cmd_response_vld | wr_ff;
   // ==========================================================
   // shadow of control registers, rebuilt from observed bus writes
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ff <= 1'b0;
         a_ff <= 8'h00;
         cfg_ff <= 8'h00;
         en_ff <= 8'h00;
         ma_ff <= 8'h00;
         mb_ff <= 8'h00;
      end else if (hready) begin
         wr_ff <= hsel & htrans[1] & hwrite;
         a_ff <= haddr;
         if (wr_ff && a_ff == `SEI_A_PIN_CFG) cfg_ff <= hwdata[7:0];
         if (wr_ff && a_ff == `SEI_A_EVT_ENABLE) en_ff <= hwdata[7:0];
         if (wr_ff && a_ff == `SEI_A_MODE_A) ma_ff <= hwdata[7:0];
         if (wr_ff && a_ff == `SEI_A_MODE_B) mb_ff <= hwdata[7:0];
      end
   end
   // ==========================================================
   // properties; pin may lag a register write by one cycle
   default clocking cb @(posedge hclk); endclocking
   // a frozen clock enable holds every state, so no promise runs then
   default disable iff (!hresetn || !clk_en);
   a_ready_high: assert property (hreadyout) else $error("wait state");
   a_resp_okay: assert property (!hresp) else $error("error response");
   a_irq_cause: assert property (
      $rose(irq_out) |-> $past(ev) || $past(wr_ff, 2)) else $error("irq up");
   a_irq_clear: assert property (
      $fell(irq_out) |-> $past(wr_ff) || $past(wr_ff, 2)) else $error("drop");
   a_pin_gated: assert property (
      !cfg_ff[0] && $past(!cfg_ff[0]) && $past(!cfg_ff[0], 2) |-> !irq_out)
      else $error("irq with pin off");
   a_prox1_every: assert property (prox1_vld && cfg_ff[0] && en_ff[2] &&
      ma_ff[5:4] == 2'h0 |=> irq_out) else $error("prox1 missed");
   a_prox2_every: assert property (prox2_vld && cfg_ff[0] && en_ff[3] &&
      ma_ff[7:6] == 2'h0 |=> irq_out) else $error("prox2 missed");
   a_prox3_every: assert property (prox3_vld && cfg_ff[0] && en_ff[4] &&
      mb_ff[1:0] == 2'h0 |=> irq_out) else $error("prox3 missed");
   a_amb_every: assert property (visible_vld && cfg_ff[0] &&
      en_ff[1:0] == 2'h1 && ma_ff[2:0] == 3'h0 |=> irq_out)
      else $error("ambient missed");
   a_cmd_every: assert property (cmd_response_vld && cfg_ff[0] &&
      en_ff[5] && !mb_ff[2] |=> irq_out) else $error("command missed");
   c_irq_up: cover property ($rose(irq_out));
   c_irq_down: cover property ($fell(irq_out));
   c_cmd_irq: cover property (cmd_response_vld ##1 irq_out);
endmodule
bind sei_event_logic sei_chk u_chk (.hclk(hclk), .hresetn(hresetn),
   .clk_en(clk_en),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
   .prox1_vld(prox1_vld), .prox2_vld(prox2_vld), .prox3_vld(prox3_vld),
   .visible_vld(visible_vld), .infrared_vld(infrared_vld),
   .cmd_response_vld(cmd_response_vld), .irq_out(irq_out));

// ---- test/sei_host.sv ----
// host model: ahb-lite master that configures and services the pin
`timescale 1ns/10ps
`include "sei_map.vh"
module sei_host (
   input  wire         hclk,
   input  wire         hreadyout,
   input  wire  [31:0] hrdata,
   output logic [7:0]  haddr,
   output logic [1:0]  htrans,
   output logic        hwrite,
   output logic [31:0] hwdata
);
   initial begin
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
   end
   // caller enters just after a rising edge; no latency is assumed
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task setup();
      logic [31:0] z;
      xfer(1'b1, `SEI_A_PIN_CFG, 32'h1, z);
   endtask
   // the copy written back clears exactly what was seen
   task service(output logic [31:0] q);
      logic [31:0] z;
      xfer(1'b0, `SEI_A_STATUS, 32'h0, q);
      xfer(1'b1, `SEI_A_STATUS, q, z);
   endtask
endmodule

// ---- test/sei_event_logic_bench.sv ----
// self-checking bench for the sensor event and interrupt pin logic
`timescale 1ns/10ps
`include "sei_map.vh"
`define CHK(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
   n_mismatch = n_mismatch + 1; $display("BAD %0t %h %h", $time, g, e); \
   end end
module sei_event_logic_bench;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        clk_en = 1'b1;
   logic [5:0]  vld = 6'h00;
   logic        err = 1'b0;
   logic [15:0] smp [0:5] = '{default: 16'h0000};
   logic [15:0] hv [0:5] = '{16'h5, 16'h12, 16'h15, 16'h1E, 16'hE, 16'hC};
   logic [31:0] q;
   logic [7:0]  th;
   logic [15:0] s;
   logic [15:0] hy;
   logic [15:0] lim;
   logic        st = 1'b0;
   wire  [7:0]  haddr;
   wire  [1:0]  htrans;
   wire         hwrite;
   wire  [31:0] hwdata;
   wire  [31:0] hrdata;
   wire         hreadyout;
   wire         hresp;
   wire         irq_out;
   integer      seed = 82;
   integer      n_mismatch = 0;
   integer      n_tests = 0;
   integer      i;
   integer      ch;
   initial forever #12.5 hclk = ~hclk;
   sei_host host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
   sei_event_logic dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
      .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .prox1_vld(vld[0]),
      .prox1_sample(smp[0]), .prox2_vld(vld[1]), .prox2_sample(smp[1]),
      .prox3_vld(vld[2]), .prox3_sample(smp[2]), .visible_vld(vld[3]),
      .visible_light_channel(smp[3]), .infrared_vld(vld[4]),
      .infrared_light_channel(smp[4]), .cmd_response_vld(vld[5]),
      .cmd_response_err(err), .irq_out(irq_out));
   function automatic [15:0] cval(input [7:0] b);
      logic [31:0] t;
      t = (32'd16 + b[3:0]) << b[7:4];
      return t[19:4];
   endfunction
   task wr(input [7:0] a, input [31:0] d);
      host.xfer(1'b1, a, d, q);
   endtask
   task chk(input [7:0] a, input [31:0] e);
      host.xfer(1'b0, a, 32'h0, q);
      `CHK(q, e)
   endtask
   // two edges let the pin follow a register write
   task clr();
      wr(`SEI_A_STATUS, 32'h3F);
      repeat (2) @(posedge hclk);
   endtask
   task pulse(input integer c, input [15:0] v);
      smp[c] <= v;
      err <= v[0];
      vld[c] <= 1'b1;
      @(posedge hclk);
      vld[c] <= 1'b0;
      @(posedge hclk);
   endtask
   task finish_test();
      if (n_mismatch == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #(25 * 5000);
      n_mismatch = n_mismatch + 1;
      finish_test();
   end
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      `CHK(irq_out, 1'b0)
      chk(`SEI_A_STATUS, 32'h0);
      host.setup();
      for (i = 0; i < 3; i = i + 1) begin
         wr(`SEI_A_EVT_ENABLE, 32'h0);
         pulse(i, 16'($random(seed)));
         chk(`SEI_A_STATUS, 32'h0);
         wr(`SEI_A_EVT_ENABLE, 32'h4 << i);
         pulse(i, 16'($random(seed)));
         chk(`SEI_A_STATUS, 32'h4 << i);
         `CHK(irq_out, 1'b1)
         clr();
         `CHK(irq_out, 1'b0)
      end
      wr(`SEI_A_EVT_ENABLE, 32'h4);
      pulse(0, 16'h0);
      wr(`SEI_A_EVT_ENABLE, 32'h0);
      clr();
      `CHK(irq_out, 1'b0)
      wr(`SEI_A_EVT_ENABLE, 32'h4);
      pulse(0, 16'h0);
      wr(`SEI_A_PIN_CFG, 32'h0);
      repeat (2) @(posedge hclk);
      `CHK(irq_out, 1'b0)
      // deassert policy set: status writes are ignored
      wr(`SEI_A_PIN_CFG, 32'h3);
      clr();
      chk(`SEI_A_STATUS, 32'h4);
      host.setup();
      wr(`SEI_A_EVT_ENABLE, 32'hC);
      pulse(1, 16'h0);
      wr(`SEI_A_STATUS, 32'h4);
      chk(`SEI_A_STATUS, 32'h8);
      host.service(q);
      chk(`SEI_A_STATUS, 32'h0);
      // frozen clock enable: a sample in that time must leave no trace
      clk_en <= 1'b0;
      pulse(0, 16'h0);
      clk_en <= 1'b1;
      chk(`SEI_A_STATUS, 32'h0);
      pulse(0, 16'h0);
      chk(`SEI_A_STATUS, 32'h4);
      clr();
      wr(`SEI_A_PROX_HYST, 32'h0);
      wr(`SEI_A_PROX_HIST, 32'h0);
      wr(`SEI_A_EVT_ENABLE, 32'h4);
      wr(`SEI_A_MODE_A, 32'h30);
      // a compressed zero still expands to one count of hysteresis
      hy = cval(8'h00);
      for (i = 0; i < 12; i = i + 1) begin
         th = 8'($random(seed)) & 8'h7F;
         s = cval(th) - 16'd2 + 16'({$random(seed)} % 5);
         lim = st ? ((cval(th) > hy) ? cval(th) - hy : 16'h0000)
                  : cval(th) + hy;
         st = s > lim;
         wr(`SEI_A_PROX_TH1, {24'h0, th});
         pulse(0, s);
         chk(`SEI_A_STATUS, st ? 32'h4 : 32'h0);
         clr();
      end
      // threshold 16, hysteresis 4: up above 20, down at 12 or less
      wr(`SEI_A_MODE_A, 32'h10);
      wr(`SEI_A_PROX_TH1, 32'h40);
      wr(`SEI_A_PROX_HYST, 32'h20);
      pulse(0, 16'h5);
      clr();
      for (i = 0; i < 6; i = i + 1) begin
         pulse(0, hv[i]);
         chk(`SEI_A_STATUS, (i == 2 || i == 5) ? 32'h4 : 32'h0);
         clr();
      end
      // two newest results must agree before the side may change
      wr(`SEI_A_PROX_HIST, 32'h3);
      pulse(0, 16'h1E);
      chk(`SEI_A_STATUS, 32'h0);
      pulse(0, 16'h1E);
      chk(`SEI_A_STATUS, 32'h4);
      clr();
      wr(`SEI_A_AMB_LOW_TH, 32'd100);
      wr(`SEI_A_AMB_HIGH_TH, 32'd200);
      wr(`SEI_A_EVT_ENABLE, 32'h1);
      wr(`SEI_A_MODE_A, 32'h0);
      pulse(3, 16'h7);
      chk(`SEI_A_STATUS, 32'h1);
      clr();
      wr(`SEI_A_EVT_ENABLE, 32'h3);
      for (ch = 3; ch < 5; ch = ch + 1) begin
         wr(`SEI_A_MODE_A, (ch == 3) ? 32'h5 : 32'h7);
         pulse(ch, 16'd50);
         clr();
         pulse(ch, 16'd100);
         chk(`SEI_A_STATUS, 32'h2);
         clr();
         pulse(ch, 16'd201);
         chk(`SEI_A_STATUS, 32'h1);
         clr();
      end
      wr(`SEI_A_EVT_ENABLE, 32'h20);
      wr(`SEI_A_MODE_B, 32'h0);
      pulse(5, 16'h0);
      chk(`SEI_A_STATUS, 32'h20);
      clr();
      wr(`SEI_A_MODE_B, 32'h4);
      pulse(5, 16'h0);
      chk(`SEI_A_STATUS, 32'h0);
      pulse(5, 16'h1);
      chk(`SEI_A_STATUS, 32'h20);
      wr(8'hF0, 32'hFFFFFFFF);
      chk(8'hF0, 32'h0);
      finish_test();
   end
endmodule
